// ### core/vco_auto_band_calibration_ctrl.sv
// VCO band calibration controller with main serial port, relock and manual switch control.
`include "vco_cal_defs.svh"
module vco_auto_band_calibration_ctrl #(
  parameter int SW_BITS = 8,
  parameter int INT_BITS = 19
) (
  // Clock, reset and enable.
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  // Main serial port.
  input wire logic SEN,
  input wire logic SCK,
  input wire logic SDI,
  output logic LOCK_DETECT_SERIAL_OUT,
  // Loop timing and lock status.
  input wire logic PD_TICK,
  input wire logic VCO_TICK,
  input wire logic LOCK_DETECT,
  // VCO serial link.
  output logic VCO_SERIAL_CLOCK,
  output logic VSDATA,
  output logic VSEN,
  // Synthesizer controls.
  output logic TUNE_HOLD_MID,
  output logic CAL_BUSY,
  output logic [23:0] FRAC_TO_MOD,
  output logic [INT_BITS-1:0] INT_TO_PRESCALER,
  output vco_cal_pkg::vco_out_s VCO_OUT
);
  import vco_cal_pkg::*;

  // Expected VCO count over 2^n phase detector periods: floor(N * 2^n).
  function automatic logic [31:0] cal_target(input logic [INT_BITS-1:0] nint,
                                             input logic [23:0] nfrac, input logic [2:0] n);
    logic [INT_BITS+23:0] full;
    full = {nint, nfrac};
    return 32'(full >> (5'd24 - {2'b00, n}));
  endfunction

  function automatic logic [31:0] abs_diff(input logic [31:0] a, input logic [31:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  // Serial port state.
  logic sck_prev_reg, sck_prev_next, sen_prev_reg, sen_prev_next;
  logic [30:0] shift_reg, shift_next;
  logic [4:0] bit_cnt_reg, bit_cnt_next;
  logic [23:0] sdo_sh_reg, sdo_sh_next;
  logic reading_reg, reading_next, serial_out_next;
  logic sck_rise, wr_commit;
  logic [5:0] wr_addr, rd_addr;
  logic [23:0] wr_data, rd_data;

  // Configuration and output state.
  logic [INT_BITS-1:0] int_reg, int_next, int_out_next;
  logic [23:0] frac_reg, frac_next, frac_out_next;
  logic [23:0] mode_reg, mode_next, lock_cfg_reg, lock_cfg_next, cal_cfg_reg, cal_cfg_next;
  logic [15:0] vco_word_reg, vco_word_next;
  logic [SW_BITS-1:0] sw_reg, sw_next;
  logic pend_reg, pend_next;
  vco_out_s vco_out_next;

  // Calibration sequencer state.
  cal_state_e state_reg, state_next;
  logic [SW_BITS-1:0] try_reg, try_next, best_reg, best_next;
  logic [31:0] err_reg, err_next, cnt_reg, cnt_next;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] pd_cnt_reg, pd_cnt_next;
  logic [8:0] wait_reg, wait_next;
  logic final_reg, final_next, req_reg, req_next, used_reg, used_next;
  logic lock_prev_reg, busy_next;

  // Link to the VCO serialiser.
  logic tx_start, tx_busy, fsm_tick;
  logic [15:0] tx_word;
  logic cal_off, unlock_evt, vco_sw_wr, vco_bias_wr;
  logic [8:0] vco_data;

  assign cal_off = cal_cfg_reg[`CAL_DISABLE_BIT];
  assign sck_rise = SEN && SCK && !sck_prev_reg;
  assign wr_commit = sen_prev_reg && !SEN && bit_cnt_reg == `FRAME_BITS && !shift_reg[30];
  assign wr_addr = shift_reg[29:24];
  assign wr_data = shift_reg[23:0];
  assign rd_addr = {shift_reg[4:0], SDI};
  assign vco_data = wr_data[15:`VW_DATA_LSB];
  assign vco_sw_wr = wr_commit && wr_addr == `ADDR_VCO_WRITE
                     && wr_data[`VW_ADDR_MSB:`VW_ADDR_LSB] == `VREG_SWITCH;
  assign vco_bias_wr = wr_commit && wr_addr == `ADDR_VCO_WRITE
                       && wr_data[`VW_ADDR_MSB:`VW_ADDR_LSB] == `VREG_BIAS;
  assign unlock_evt = lock_prev_reg && !LOCK_DETECT && lock_cfg_reg[`RELOCK_BIT]
                      && !used_reg && !cal_off;

  // Read decode; unmapped offsets read as zero.
  always_comb begin
    if (rd_addr == `ADDR_INTEGER) begin
      rd_data = 24'(int_reg);
    end else if (rd_addr == `ADDR_FRACT) begin
      rd_data = frac_reg;
    end else if (rd_addr == `ADDR_MODE) begin
      rd_data = mode_reg;
    end else if (rd_addr == `ADDR_LOCK_CFG) begin
      rd_data = lock_cfg_reg;
    end else if (rd_addr == `ADDR_CAL_CFG) begin
      rd_data = cal_cfg_reg;
    end else if (rd_addr == `ADDR_SW_READBACK) begin
      rd_data = 24'(sw_reg);
    end else begin
      rd_data = 24'h000000;
    end
  end

  // Main serial port: read/write bit, 6-bit address, 24 data bits, all MSB first.
  always_comb begin
    sck_prev_next = SCK;
    sen_prev_next = SEN;
    shift_next = shift_reg;
    bit_cnt_next = SEN ? bit_cnt_reg : 5'd0;
    sdo_sh_next = sdo_sh_reg;
    reading_next = SEN && reading_reg;
    if (sck_rise) begin
      shift_next = {shift_reg[29:0], SDI};
      bit_cnt_next = (bit_cnt_reg == `FRAME_BITS) ? bit_cnt_reg : bit_cnt_reg + 5'd1;
      if (bit_cnt_reg == `HEAD_BITS - 5'd1) begin
        reading_next = shift_reg[5];
        sdo_sh_next = rd_data;
      end else if (reading_reg) begin
        sdo_sh_next = {sdo_sh_reg[22:0], 1'b0};
      end
    end
    // Outside a read frame the pin reports lock.
    serial_out_next = reading_next ? sdo_sh_next[23] : LOCK_DETECT;
  end

  // Register writes, immediate loads and manual VCO control.
  always_comb begin
    int_next = int_reg;
    frac_next = frac_reg;
    mode_next = mode_reg;
    lock_cfg_next = lock_cfg_reg;
    cal_cfg_next = cal_cfg_reg;
    vco_word_next = vco_word_reg;
    int_out_next = INT_TO_PRESCALER;
    frac_out_next = FRAC_TO_MOD;
    vco_out_next = VCO_OUT;
    sw_next = sw_reg;
    pend_next = pend_reg && !(tx_start && state_reg == CAL_IDLE);
    // A request waits while the serialiser is busy; one raised as it is taken survives.
    req_next = req_reg && !(state_reg == CAL_IDLE && !tx_busy);
    // Calibrated values load first, so a same-cycle write with calibration off still wins.
    if (state_reg == CAL_DONE) begin
      frac_out_next = frac_reg;
      int_out_next = int_reg;
    end
    if (wr_commit) begin
      if (wr_addr == `ADDR_INTEGER) begin
        int_next = wr_data[INT_BITS-1:0];
        if (cal_off) begin
          int_out_next = wr_data[INT_BITS-1:0];
        end else if (!mode_reg[`FRAC_MODE_BIT]) begin
          req_next = 1'b1;
        end
      end else if (wr_addr == `ADDR_FRACT) begin
        frac_next = wr_data;
        if (cal_off) begin
          frac_out_next = wr_data;
        end else if (mode_reg[`FRAC_MODE_BIT]) begin
          req_next = 1'b1;
        end
      end else if (wr_addr == `ADDR_VCO_WRITE) begin
        vco_word_next = wr_data[15:0];
        pend_next = 1'b1;
      end else if (wr_addr == `ADDR_MODE) begin
        mode_next = wr_data;
      end else if (wr_addr == `ADDR_LOCK_CFG) begin
        lock_cfg_next = wr_data;
      end else if (wr_addr == `ADDR_CAL_CFG) begin
        cal_cfg_next = wr_data;
      end
    end
    if (unlock_evt && state_reg == CAL_IDLE) begin
      req_next = 1'b1;
    end
    if (vco_sw_wr) begin
      sw_next = vco_data[SW_BITS-1:0];
    end else if (state_reg == CAL_DONE) begin
      sw_next = best_reg;
    end
    // Odd divide values other than 1, zero and out-of-range values are not taken.
    if (vco_bias_wr && (vco_data[5:0] == `DIVIDE_RESET
        || (!vco_data[0] && vco_data[5:0] != 6'h00 && vco_data[5:0] <= `DIVIDE_MAX))) begin
      vco_out_next.divide = vco_data[5:0];
    end
    if (vco_bias_wr) begin
      vco_out_next.gain = vco_data[7:6];
    end
    if (wr_commit && wr_addr == `ADDR_VCO_WRITE
        && wr_data[`VW_ADDR_MSB:`VW_ADDR_LSB] == `VREG_CONFIG) begin
      vco_out_next.doubler = vco_data[0];
    end
    vco_out_next.mode = vco_out_next.doubler ? MODE_DOUBLED :
                        (vco_out_next.divide == `DIVIDE_RESET) ? MODE_FUNDAMENTAL : MODE_DIVIDED;
  end

  // Calibrator words keep the address and identifier that the host placed in the VCO word.
  always_comb begin
    tx_start = 1'b0;
    tx_word = vco_word_reg;
    if (state_reg == CAL_SEND) begin
      tx_start = !tx_busy;
      tx_word = {9'(final_reg ? best_reg : try_reg), vco_word_reg[`VW_KEEP_MSB:0]};
    end else if (state_reg == CAL_IDLE && pend_reg && !req_reg) begin
      tx_start = !tx_busy;
    end
  end

  // Successive approximation over the switch bits, remembering the closest count seen.
  always_comb begin
    state_next = state_reg;
    try_next = try_reg;
    best_next = best_reg;
    err_next = err_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    pd_cnt_next = pd_cnt_reg;
    wait_next = wait_reg;
    final_next = final_reg;
    used_next = (used_reg && !LOCK_DETECT) || (unlock_evt && state_reg == CAL_IDLE);
    case (state_reg)
      CAL_IDLE: begin
        if (req_reg && !tx_busy) begin
          state_next = CAL_SEND;
          bit_next = 3'(SW_BITS - 1);
          try_next = SW_BITS'(1) << (SW_BITS - 1);
          err_next = 32'hffffffff;
          final_next = 1'b0;
        end
      end
      CAL_SEND: begin
        if (tx_start) begin
          state_next = CAL_XFER;
        end
      end
      CAL_XFER: begin
        wait_next = 9'd0;
        if (!tx_busy) begin
          state_next = final_reg ? CAL_DONE : CAL_SETTLE;
        end
      end
      CAL_SETTLE: begin
        cnt_next = 32'h0;
        pd_cnt_next = 8'h00;
        if (wait_reg >= `WAIT_UNIT * {7'h00, cal_cfg_reg[`WAITK_MSB:`WAITK_LSB]}) begin
          state_next = CAL_MEAS;
        end else if (fsm_tick) begin
          wait_next = wait_reg + 9'd1;
        end
      end
      CAL_MEAS: begin
        cnt_next = cnt_reg + {31'h0, VCO_TICK};
        pd_cnt_next = pd_cnt_reg + {7'h00, PD_TICK};
        if (pd_cnt_reg == (8'h01 << cal_cfg_reg[`MEASN_MSB:`MEASN_LSB])) begin
          state_next = CAL_JUDGE;
          cnt_next = cnt_reg;
        end
      end
      CAL_JUDGE: begin
        if (abs_diff(cnt_reg, cal_target(int_reg, frac_reg,
            cal_cfg_reg[`MEASN_MSB:`MEASN_LSB])) < err_reg) begin
          best_next = try_reg;
          err_next = abs_diff(cnt_reg, cal_target(int_reg, frac_reg,
                              cal_cfg_reg[`MEASN_MSB:`MEASN_LSB]));
        end
        // Running fast means too little capacitance, so the trial bit stays set.
        if (cnt_reg <= cal_target(int_reg, frac_reg, cal_cfg_reg[`MEASN_MSB:`MEASN_LSB])) begin
          try_next = try_reg & ~(SW_BITS'(1) << bit_reg);
        end
        if (bit_reg == 3'd0) begin
          final_next = 1'b1;
        end else begin
          bit_next = bit_reg - 3'd1;
          try_next = try_next | (SW_BITS'(1) << (bit_reg - 3'd1));
        end
        state_next = CAL_SEND;
      end
      CAL_DONE: begin
        state_next = CAL_IDLE;
      end
      default: begin
        state_next = CAL_IDLE;
      end
    endcase
    busy_next = state_next != CAL_IDLE;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sck_prev_reg <= 1'b0;
      sen_prev_reg <= 1'b0;
      shift_reg <= 31'h0;
      bit_cnt_reg <= 5'd0;
      sdo_sh_reg <= 24'h0;
      reading_reg <= 1'b0;
      LOCK_DETECT_SERIAL_OUT <= 1'b0;
      int_reg <= '0;
      frac_reg <= 24'h0;
      mode_reg <= `MODE_RESET;
      lock_cfg_reg <= `LOCK_CFG_RESET;
      cal_cfg_reg <= `CAL_CFG_RESET;
      vco_word_reg <= 16'h0000;
      INT_TO_PRESCALER <= '0;
      FRAC_TO_MOD <= 24'h0;
      VCO_OUT <= '{mode: MODE_FUNDAMENTAL, divide: `DIVIDE_RESET, gain: 2'h0, doubler: 1'b0};
      sw_reg <= '0;
      pend_reg <= 1'b0;
      req_reg <= 1'b0;
      state_reg <= CAL_IDLE;
      try_reg <= '0;
      best_reg <= '0;
      err_reg <= 32'h0;
      cnt_reg <= 32'h0;
      bit_reg <= 3'd0;
      pd_cnt_reg <= 8'h00;
      wait_reg <= 9'd0;
      final_reg <= 1'b0;
      used_reg <= 1'b0;
      lock_prev_reg <= 1'b0;
      CAL_BUSY <= 1'b0;
      TUNE_HOLD_MID <= 1'b0;
    end else if (CE) begin
      sck_prev_reg <= sck_prev_next;
      sen_prev_reg <= sen_prev_next;
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      sdo_sh_reg <= sdo_sh_next;
      reading_reg <= reading_next;
      LOCK_DETECT_SERIAL_OUT <= serial_out_next;
      int_reg <= int_next;
      frac_reg <= frac_next;
      mode_reg <= mode_next;
      lock_cfg_reg <= lock_cfg_next;
      cal_cfg_reg <= cal_cfg_next;
      vco_word_reg <= vco_word_next;
      INT_TO_PRESCALER <= int_out_next;
      FRAC_TO_MOD <= frac_out_next;
      VCO_OUT <= vco_out_next;
      sw_reg <= sw_next;
      pend_reg <= pend_next;
      req_reg <= req_next;
      state_reg <= state_next;
      try_reg <= try_next;
      best_reg <= best_next;
      err_reg <= err_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      pd_cnt_reg <= pd_cnt_next;
      wait_reg <= wait_next;
      final_reg <= final_next;
      used_reg <= used_next;
      lock_prev_reg <= LOCK_DETECT;
      CAL_BUSY <= busy_next;
      TUNE_HOLD_MID <= busy_next;
    end
  end

  vco_serial_tx u_tx (
    .clk(CLK),
    .resetn(RESETN),
    .ce(CE),
    .div_sel(cal_cfg_reg[`CLKDIV_MSB:`CLKDIV_LSB]),
    .start(tx_start),
    .word(tx_word),
    .busy(tx_busy),
    .fsm_tick(fsm_tick),
    .sclk(VCO_SERIAL_CLOCK),
    .vsdata(VSDATA),
    .vsen(VSEN)
  );

  // Checks on the calibration and register behaviour.
  sequence s_cal_write;
    wr_commit && !cal_off && ((wr_addr == `ADDR_FRACT && mode_reg[`FRAC_MODE_BIT])
      || (wr_addr == `ADDR_INTEGER && !mode_reg[`FRAC_MODE_BIT]));
  endsequence
  sequence s_cal_taken;
    ##[1:2] (state_reg != CAL_IDLE || req_reg);
  endsequence
  property p_div_legal;
    @(posedge CLK) disable iff (!RESETN) VCO_OUT.divide == `DIVIDE_RESET
      || (!VCO_OUT.divide[0] && VCO_OUT.divide != 6'h00 && VCO_OUT.divide <= `DIVIDE_MAX);
  endproperty
  a_div_legal: assert property (p_div_legal) else $error("Illegal output divide");
  property p_gain;
    @(posedge CLK) disable iff (!RESETN || !CE) vco_bias_wr
      |=> VCO_OUT.gain == $past(vco_data[7:6]);
  endproperty
  a_gain: assert property (p_gain) else $error("Gain not taken from bias write");
  property p_auto_start;
    @(posedge CLK) disable iff (!RESETN || !CE) s_cal_write |-> s_cal_taken;
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("Write did not calibrate");
  property p_hold_mid;
    @(posedge CLK) disable iff (!RESETN) TUNE_HOLD_MID == (state_reg != CAL_IDLE);
  endproperty
  a_hold_mid: assert property (p_hold_mid) else $error("Tuning not held");
  property p_addr_kept;
    @(posedge CLK) disable iff (!RESETN) (state_reg == CAL_SEND && tx_start)
      |-> tx_word[`VW_KEEP_MSB:0] == vco_word_reg[`VW_KEEP_MSB:0];
  endproperty
  a_addr_kept: assert property (p_addr_kept) else $error("Calibration altered VCO address");
  property p_relock;
    @(posedge CLK) disable iff (!RESETN || !CE) (unlock_evt && state_reg == CAL_IDLE)
      |=> req_reg && used_reg;
  endproperty
  a_relock: assert property (p_relock) else $error("Unlock did not start relock");
  property p_readback;
    @(posedge CLK) disable iff (!RESETN || !CE) (state_reg == CAL_DONE && !vco_sw_wr)
      |=> sw_reg == $past(best_reg);
  endproperty
  a_readback: assert property (p_readback) else $error("Readback not updated");
  property p_immediate;
    @(posedge CLK) disable iff (!RESETN || !CE) (wr_commit && wr_addr == `ADDR_FRACT && cal_off)
      |=> FRAC_TO_MOD == $past(wr_data);
  endproperty
  a_immediate: assert property (p_immediate) else $error("Fraction not loaded at once");
  property p_mod_hold;
    @(posedge CLK) disable iff (!RESETN || !CE) (state_reg != CAL_IDLE && state_reg != CAL_DONE
      && !cal_off && !(wr_commit && cal_cfg_next[`CAL_DISABLE_BIT])) |=> $stable(FRAC_TO_MOD);
  endproperty
  a_mod_hold: assert property (p_mod_hold) else $error("Modulator changed early");
  property p_sw_hold;
    @(posedge CLK) disable iff (!RESETN || !CE) (state_reg != CAL_DONE && !vco_sw_wr)
      |=> $stable(sw_reg);
  endproperty
  a_sw_hold: assert property (p_sw_hold) else $error("Switch setting changed unasked");
endmodule

// ### common/vco_cal_defs.svh
// Register offsets, field positions, reset values and counts of the VCO band calibration block.
`ifndef VCO_CAL_DEFS_SVH
`define VCO_CAL_DEFS_SVH
`define ADDR_INTEGER 6'h03
`define ADDR_FRACT 6'h04
`define ADDR_VCO_WRITE 6'h05
`define ADDR_MODE 6'h06
`define ADDR_LOCK_CFG 6'h07
`define ADDR_CAL_CFG 6'h0a
`define ADDR_SW_READBACK 6'h10
`define FRAC_MODE_BIT 11
`define RELOCK_BIT 13
`define CAL_DISABLE_BIT 11
`define CLKDIV_MSB 14
`define CLKDIV_LSB 13
`define WAITK_MSB 7
`define WAITK_LSB 6
`define MEASN_MSB 2
`define MEASN_LSB 0
`define VW_ADDR_MSB 6
`define VW_ADDR_LSB 3
`define VW_KEEP_MSB 6
`define VW_DATA_LSB 7
`define VREG_SWITCH 4'h0
`define VREG_BIAS 4'h2
`define VREG_CONFIG 4'h3
`define FRAME_BITS 5'd31
`define HEAD_BITS 5'd7
`define WAIT_UNIT 9'd128
`define VSPI_BITS 5'd16
`define MODE_RESET 24'h000800
`define LOCK_CFG_RESET 24'h002000
`define CAL_CFG_RESET 24'h000005
`define DIVIDE_RESET 6'h01
`define DIVIDE_MAX 6'h3e
`endif

// ### common/vco_cal_pkg.sv
// Types shared by the VCO band calibration block.
package vco_cal_pkg;
  // Calibration sequencer states, Gray coded in the order listed.
  typedef enum logic [2:0] {
    CAL_IDLE = 3'b000,
    CAL_SEND = 3'b001,
    CAL_XFER = 3'b011,
    CAL_SETTLE = 3'b010,
    CAL_MEAS = 3'b110,
    CAL_JUDGE = 3'b111,
    CAL_DONE = 3'b101
  } cal_state_e;
  // Output frequency mode of the VCO subsystem.
  typedef enum logic [1:0] {
    MODE_FUNDAMENTAL = 2'h0,
    MODE_DIVIDED = 2'h1,
    MODE_DOUBLED = 2'h2
  } vco_mode_e;
  // VCO output stage settings as mirrored from writes to the VCO.
  typedef struct packed {
    vco_mode_e mode;
    logic [5:0] divide;
    logic [1:0] gain;
    logic doubler;
  } vco_out_s;
endpackage

// ### core/vco_serial_tx.sv
// Serialiser that sends one 16-bit word to the VCO subsystem on the divided serial clock.
`include "vco_cal_defs.svh"
module vco_serial_tx (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Divider choice and word request.
  input wire logic [1:0] div_sel,
  input wire logic start,
  input wire logic [15:0] word,
  // Status and serial pins.
  output logic busy,
  output logic fsm_tick,
  output logic sclk,
  output logic vsdata,
  output logic vsen
);
  logic [5:0] div_cnt_reg, div_cnt_next, div_last;
  logic [15:0] sh_reg, sh_next;
  logic [4:0] bits_reg, bits_next;
  logic busy_next, tick_next, sclk_next, vsdata_next;

  // Half-period lengths 1, 4, 16 and 32 reference cycles; each serial bit takes two ticks.
  always_comb begin
    case (div_sel)
      2'h0: div_last = 6'd0;
      2'h1: div_last = 6'd3;
      2'h2: div_last = 6'd15;
      default: div_last = 6'd31;
    endcase
  end

  // Divider and shifter: data changes with the low phase, the VCO samples on the rise.
  always_comb begin
    div_cnt_next = (div_cnt_reg >= div_last) ? 6'd0 : div_cnt_reg + 6'd1;
    tick_next = (div_cnt_reg >= div_last);
    sh_next = sh_reg;
    bits_next = bits_reg;
    busy_next = busy;
    sclk_next = sclk;
    vsdata_next = vsdata;
    if (start && !busy) begin
      // The first bit must already stand on the line when the first rise comes.
      sh_next = {word[14:0], 1'b0};
      vsdata_next = word[15];
      bits_next = 5'd0;
      busy_next = 1'b1;
    end else if (busy && fsm_tick) begin
      if (sclk) begin
        sclk_next = 1'b0;
        if (bits_reg == `VSPI_BITS) begin
          busy_next = 1'b0;
        end else begin
          vsdata_next = sh_reg[15];
          sh_next = {sh_reg[14:0], 1'b0};
        end
      end else if (bits_reg != `VSPI_BITS || vsen) begin
        sclk_next = (bits_reg != `VSPI_BITS) && vsen;
        bits_next = vsen ? bits_reg + 5'd1 : bits_reg;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt_reg <= 6'd0;
      sh_reg <= 16'h0000;
      bits_reg <= 5'd0;
      busy <= 1'b0;
      fsm_tick <= 1'b0;
      sclk <= 1'b0;
      vsdata <= 1'b0;
      vsen <= 1'b0;
    end else if (ce) begin
      div_cnt_reg <= div_cnt_next;
      sh_reg <= sh_next;
      bits_reg <= bits_next;
      busy <= busy_next;
      fsm_tick <= tick_next;
      sclk <= sclk_next;
      vsdata <= vsdata_next;
      vsen <= busy_next;
    end
  end

  // Helper count of serial clock rises within one enable window.
  logic [4:0] rise_cnt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rise_cnt <= 5'd0;
    end else if (ce) begin
      rise_cnt <= !vsen ? 5'd0 : rise_cnt + {4'h0, sclk_next & ~sclk};
    end
  end

  property p_sixteen_clocks;
    @(posedge clk) disable iff (!resetn || !ce) $fell(vsen) |-> rise_cnt == 5'd16;
  endproperty
  a_sixteen_clocks: assert property (p_sixteen_clocks)
    else $error("VCO transfer did not take 16 serial clocks");
endmodule

// ### dv/host_model.sv
// Host side of the main serial port: 31-bit frames on SEN, SCK and SDI.
module host_model (
  input wire logic clk,
  input wire logic sdo,
  output logic sen,
  output logic sck,
  output logic sdi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sen = 1'b0;
    sck = 1'b0;
    sdi = 1'b0;
  end
  // Each SCK phase lasts two cycles; read data is taken just before each later rise.
  task automatic xfer(input logic rd, input logic [5:0] a, input logic [23:0] d,
                      output logic [23:0] q);
    logic [30:0] bits;
    bits = {rd, a, d};
    q = 24'h0;
    @(negedge clk) sen <= 1'b1;
    for (int i = 30; i >= 0; i--) begin
      sck <= 1'b0;
      sdi <= bits[i];
      repeat (2) @(negedge clk);
      if (i <= 23) begin
        q[i] = sdo;
      end
      sck <= 1'b1;
      repeat (2) @(negedge clk);
    end
    sck <= 1'b0;
    @(negedge clk) sen <= 1'b0;
    // A deselected data line does not keep its last level.
    sdi <= ~sdi;
    repeat (2) @(negedge clk);
  endtask
endmodule

// ### dv/testbench.sv
// Self-checking bench for the VCO band calibration controller.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import vco_cal_pkg::*;
  logic clk, resetn, sen, sck, sdi, serial_out, lock;
  logic pd_tick = 1'b0;
  logic vco_tick = 1'b0;
  logic vsclk, vsdata, vsen, hold_mid, cal_busy, vsclk_d, vsen_d;
  logic [1:0] ph = 2'h0;
  logic [15:0] vword;
  logic [23:0] frac, rd;
  logic [18:0] intg;
  vco_out_s vout;
  int num_errors = 0;
  int total_checks = 0;
  int rises = 0;
  vco_auto_band_calibration_ctrl i_dut (.CLK(clk), .RESETN(resetn), .CE(1'b1), .SEN(sen), .SCK(sck),
    .SDI(sdi), .LOCK_DETECT_SERIAL_OUT(serial_out), .PD_TICK(pd_tick), .VCO_TICK(vco_tick),
    .LOCK_DETECT(lock), .VCO_SERIAL_CLOCK(vsclk), .VSDATA(vsdata), .VSEN(vsen),
    .TUNE_HOLD_MID(hold_mid),
    .CAL_BUSY(cal_busy), .FRAC_TO_MOD(frac), .INT_TO_PRESCALER(intg), .VCO_OUT(vout));
  host_model i_host (.clk(clk), .sdo(serial_out), .sen(sen), .sck(sck), .sdi(sdi));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Phase detector pulse every fourth cycle; VCO edges every other cycle.
  always @(negedge clk) begin
    ph <= ph + 2'h1;
    pd_tick <= (ph == 2'h3);
    vco_tick <= ~vco_tick;
  end
  // VCO side of the link: each transfer restarts the count and the collected word.
  always @(negedge clk) begin
    vsclk_d <= vsclk;
    vsen_d <= vsen;
    if (vsen === 1'b1 && vsen_d !== 1'b1) begin
      rises <= 0;
      vword <= 16'h0000;
    end else if (vsen === 1'b1 && vsclk === 1'b1 && vsclk_d === 1'b0) begin
      rises <= rises + 1;
      vword <= {vword[14:0], vsdata};
    end
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    i_host.xfer(1'b0, a, d, rd);
  endtask
  // Bounded wait for the busy level; a limit that runs out shows as a mismatch.
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (cal_busy !== lvl && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk({23'h0, cal_busy}, {23'h0, lvl});
  endtask
  task automatic t_regs();
    i_host.xfer(1'b1, 6'h06, 24'h0, rd);
    chk(rd, 24'h000800);
    i_host.xfer(1'b1, 6'h0a, 24'h0, rd);
    chk(rd, 24'h000005);
    i_host.xfer(1'b1, 6'h3f, 24'h0, rd);
    chk(rd, 24'h000000);
    $display("test regs done");
  endtask
  task automatic t_link();
    wr(6'h05, 24'h004210);
    chk({16'h0, vout.gain, vout.divide}, {16'h0, 2'h2, 6'h04});
    chk({22'h0, vout.mode}, {22'h0, MODE_DIVIDED});
    wait_busy(1'b0);
    repeat (40) @(negedge clk);
    chk(24'(rises), 24'd16);
    chk({8'h0, vword}, 24'h004210);
    $display("test link done");
  endtask
  task automatic t_manual();
    wr(6'h0a, 24'h000805);
    wr(6'h05, 24'h002d00);
    wr(6'h04, 24'h123456);
    chk(frac, 24'h123456);
    chk({23'h0, cal_busy}, 24'h0);
    chk({8'h0, vword}, 24'h002d00);
    i_host.xfer(1'b1, 6'h10, 24'h0, rd);
    chk(rd, 24'h00005a);
    wr(6'h03, 24'h000123);
    chk({5'h0, intg}, 24'h000123);
    $display("test manual done");
  endtask
  task automatic t_auto_band_calibration();
    wr(6'h0a, 24'h000005);
    wr(6'h05, 24'h000005);
    wr(6'h04, 24'h000abc);
    chk({23'h0, hold_mid}, 24'h1);
    chk(frac, 24'h123456);
    wait_busy(1'b0);
    @(negedge clk);
    chk(frac, 24'h000abc);
    chk({17'h0, vword[6:0]}, 24'h000005);
    i_host.xfer(1'b1, 6'h10, 24'h0, rd);
    chk(rd, {16'h0, vword[14:7]});
    $display("test auto_band_calibration done");
  endtask
  task automatic t_relock();
    lock = 1'b0;
    wait_busy(1'b1);
    chk({23'h0, serial_out}, 24'h0);
    wait_busy(1'b0);
    repeat (300) @(negedge clk);
    chk({23'h0, cal_busy}, 24'h0);
    lock = 1'b1;
    $display("test relock done");
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    lock = 1'b1;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    t_regs();
    t_link();
    t_manual();
    t_auto_band_calibration();
    t_relock();
    give_verdict();
  end
  initial begin
    #500us;
    num_errors++;
    give_verdict();
  end
endmodule
